// ===== src/gpio_port_map.svh
`ifndef GPIO_PORT_MAP_SVH
`define GPIO_PORT_MAP_SVH

// Port geometry
`define PORT_WIDTH            8
`define APB_ADDR_WIDTH        12

// Register byte offsets
`define PORT_PIN_DATA_OFS     12'h000
`define PIN_DIRECTION_OFS     12'h004
`define ANALOG_SELECT_OFS     12'h008
`define OUTPUT_LATCH_OFS      12'h00C
`define PORT_BIT_SET_OFS      12'h010
`define PORT_BIT_CLEAR_OFS    12'h014
`define PORT_BIT_TOGGLE_OFS   12'h018

// Reset values
`define PIN_DIRECTION_RESET   8'hFF
`define ANALOG_SELECT_RESET   8'hFF
`define OUTPUT_LATCH_RESET    8'h00
`define READ_DATA_RESET       32'h00000000

// Field positions of the port byte inside a bus word
`define PORT_BYTE_LSB         0
`define PORT_BYTE_MSB         7
`define PORT_BYTE_STRB        0

// Pins feeding the shared peripherals
`define TIMER_GATE_PIN        0
`define CAP_SENSE_B_LSB       0
`define CAP_SENSE_B_MSB       2
`define CAP_SENSE_A_LSB       3
`define CAP_SENSE_A_MSB       7

`endif

// ===== src/gpio_port_pkg.sv
`include "gpio_port_map.svh"

package gpio_port_pkg;

    typedef logic [`PORT_WIDTH-1:0] port_byte_type;

    typedef struct packed {
        logic                       psel;
        logic                       penable;
        logic                       pwrite;
        logic [`APB_ADDR_WIDTH-1:0] paddr;
        logic [31:0]                pwdata;
        logic [3:0]                 pstrb;
    } apb_req_type;

    typedef struct packed {
        port_byte_type pin_out;
        port_byte_type pin_oe_b;
    } pad_drive_type;

    typedef struct packed {
        port_byte_type latch;
        port_byte_type direction;
        port_byte_type analog_sel;
        logic [31:0]   rdata;
        logic          slverr;
        logic          loaded;
    } port_state_type;

    typedef struct packed {
        port_byte_type level_meta;
        port_byte_type level_sync;
    } sync_state_type;

endpackage

// ===== src/pin_sync.sv
`timescale 1ns/1ns

module pin_sync #(
    parameter int PINS = 8
) (
    input  wire logic            mclk,
    input  wire logic            rst_b,
    input  wire logic            clk_en,
    input  wire logic [PINS-1:0] pin_raw,
    output logic      [PINS-1:0] pin_level
);

    if (PINS < 1) begin : g_bad_pins
        $error("pin_sync: PINS must be at least one");
    end

    logic [PINS-1:0] meta_reg;
    logic [PINS-1:0] sync_reg;

    // Only the second stage is ever read
    generate
        for (genvar i = 0; i < PINS; i++) begin : g_bit
            always_ff @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    meta_reg[i] <= 1'b0;
                    sync_reg[i] <= 1'b0;
                end else if (clk_en) begin
                    meta_reg[i] <= pin_raw[i];
                    sync_reg[i] <= meta_reg[i];
                end
            end
        end
    endgenerate

    assign pin_level = sync_reg;

endmodule

// ===== src/pin_pad.sv
`timescale 1ns/1ns

module pin_pad #(
    parameter int PINS = 8
) (
    input  wire logic [PINS-1:0] pin_level,
    input  wire logic [PINS-1:0] latch,
    input  wire logic [PINS-1:0] direction,
    input  wire logic [PINS-1:0] analog_sel,
    output logic      [PINS-1:0] digital_in,
    output logic      [PINS-1:0] pin_out,
    output logic      [PINS-1:0] pin_oe_b
);

    if (PINS < 1) begin : g_bad_pins
        $error("pin_pad: PINS must be at least one");
    end

    generate
        for (genvar i = 0; i < PINS; i++) begin : g_pin
            // Driver follows direction alone, analog select ignored
            assign pin_oe_b[i]   = direction[i];
            assign pin_out[i]    = latch[i];
            // Input buffer off in analog mode
            assign digital_in[i] = pin_level[i] & ~analog_sel[i];
        end
    endgenerate

endmodule

// ===== src/gpio_port.sv
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ns
`include "gpio_port_map.svh"

module gpio_port #(
    parameter int PINS = `PORT_WIDTH
) (
    input  wire logic                        mclk,
    input  wire logic                        rst_b,
    input  wire logic                        clk_en,
    input  wire gpio_port_pkg::apb_req_type  apb_req,
    output logic                             pready,
    output logic [31:0]                      prdata,
    output logic                             pslverr,
    input  wire logic [PINS-1:0]             pin_in,
    output gpio_port_pkg::pad_drive_type     pad_drive,
    output logic [`CAP_SENSE_A_MSB-`CAP_SENSE_A_LSB:0] cap_sense_a_channel,
    output logic [`CAP_SENSE_B_MSB-`CAP_SENSE_B_LSB:0] cap_sense_b_channel,
    output logic                             timer_gate_input
);

    // Refuse geometries that the fixed port byte cannot serve
    if (PINS != `PORT_WIDTH) begin : g_bad_pins
        $error("gpio_port: PINS must equal the port width");
    end
    if (`TIMER_GATE_PIN >= PINS) begin : g_bad_gate
        $error("gpio_port: timer gate pin lies outside the port");
    end
    if (`CAP_SENSE_A_MSB >= PINS) begin : g_bad_sense
        $error("gpio_port: sense channels lie outside the port");
    end

    gpio_port_pkg::port_state_type st_reg;
    gpio_port_pkg::port_state_type st_next;

    gpio_port_pkg::port_byte_type pin_level;
    gpio_port_pkg::port_byte_type digital_in;
    gpio_port_pkg::port_byte_type pad_out;
    gpio_port_pkg::port_byte_type pad_oe_b;

    logic        setup_load;
    logic        access_done;
    logic        lane_ok;
    logic [7:0]  wbyte;

    pin_sync #(
        .PINS      (PINS)
    ) u_sync (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .clk_en    (clk_en),
        .pin_raw   (pin_in),
        .pin_level (pin_level)
    );

    pin_pad #(
        .PINS       (PINS)
    ) u_pad (
        .pin_level  (pin_level),
        .latch      (st_reg.latch),
        .direction  (st_reg.direction),
        .analog_sel (st_reg.analog_sel),
        .digital_in (digital_in),
        .pin_out    (pad_out),
        .pin_oe_b   (pad_oe_b)
    );

    // Per-pin drivers for all eight pins
    assign pad_drive.pin_out  = pad_out;
    assign pad_drive.pin_oe_b = pad_oe_b;

    // Capacitive sensing is an analog path, so it taps the synchronized level ahead of the analog gating
    assign cap_sense_a_channel =
        pin_level[`CAP_SENSE_A_MSB:`CAP_SENSE_A_LSB];
    assign cap_sense_b_channel =
        pin_level[`CAP_SENSE_B_MSB:`CAP_SENSE_B_LSB];
    // Timer gate is digital and sees the gated input
    assign timer_gate_input = digital_in[`TIMER_GATE_PIN];

    // Read data captured one cycle ahead of the access phase
    assign pready  = st_reg.loaded & clk_en;
    assign prdata  = st_reg.rdata;
    assign pslverr = st_reg.slverr;

    assign setup_load  = apb_req.psel & ~st_reg.loaded;
    assign access_done = apb_req.psel & apb_req.penable & pready;
    assign lane_ok     = apb_req.pstrb[`PORT_BYTE_STRB];
    assign wbyte       = apb_req.pwdata[`PORT_BYTE_MSB:`PORT_BYTE_LSB];

    always_comb begin
        st_next = st_reg;
        if (setup_load) begin
            st_next.loaded = 1'b1;
            st_next.rdata  = `READ_DATA_RESET;
            st_next.slverr = 1'b0;
            unique case (apb_req.paddr)
                `PORT_PIN_DATA_OFS: begin
                    // Pins, not latch
                    st_next.rdata[`PORT_BYTE_MSB:`PORT_BYTE_LSB] =
                        digital_in;
                end
                `PIN_DIRECTION_OFS: begin
                    st_next.rdata[`PORT_BYTE_MSB:`PORT_BYTE_LSB] =
                        st_reg.direction;
                end
                `ANALOG_SELECT_OFS: begin
                    st_next.rdata[`PORT_BYTE_MSB:`PORT_BYTE_LSB] =
                        st_reg.analog_sel;
                end
                `OUTPUT_LATCH_OFS: begin
                    st_next.rdata[`PORT_BYTE_MSB:`PORT_BYTE_LSB] =
                        st_reg.latch;
                end
                `PORT_BIT_SET_OFS,
                `PORT_BIT_CLEAR_OFS,
                `PORT_BIT_TOGGLE_OFS: begin
                    st_next.rdata = `READ_DATA_RESET;
                end
                default: begin
                    st_next.slverr = 1'b1;
                end
            endcase
        end
        if (access_done) begin
            st_next.loaded = 1'b0;
            if (apb_req.pwrite && !st_reg.slverr && lane_ok) begin
                unique case (apb_req.paddr)
                    `PORT_PIN_DATA_OFS: begin
                        // Whole byte modified, sampled pins fully replaced
                        st_next.latch = wbyte;
                    end
                    `PIN_DIRECTION_OFS: begin
                        st_next.direction = wbyte;
                    end
                    `ANALOG_SELECT_OFS: begin
                        st_next.analog_sel = wbyte;
                    end
                    // Analog pins read 0 here, so clear leaves them 0 in the latch and set or toggle loads the written bit
                    `PORT_BIT_SET_OFS: begin
                        st_next.latch = digital_in | wbyte;
                    end
                    `PORT_BIT_CLEAR_OFS: begin
                        st_next.latch = digital_in & ~wbyte;
                    end
                    `PORT_BIT_TOGGLE_OFS: begin
                        st_next.latch = digital_in ^ wbyte;
                    end
                    default: begin
                        st_next.latch = st_reg.latch;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg.latch      <= `OUTPUT_LATCH_RESET;
            st_reg.direction  <= `PIN_DIRECTION_RESET;
            st_reg.analog_sel <= `ANALOG_SELECT_RESET;
            st_reg.rdata      <= `READ_DATA_RESET;
            st_reg.slverr     <= 1'b0;
            st_reg.loaded     <= 1'b0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

endmodule

// ===== dv/gpio_port_assertions.sv
`timescale 1ns/1ns
`include "gpio_port_map.svh"
module gpio_port_assertions (
    input wire logic                         mclk,
    input wire logic                         rst_b,
    input wire logic                         clk_en,
    input wire gpio_port_pkg::apb_req_type   apb_req,
    input wire logic                         pready,
    input wire logic [31:0]                  prdata,
    input wire logic                         pslverr,
    input wire logic [7:0]                   pin_in,
    input wire gpio_port_pkg::pad_drive_type pad_drive,
    input wire logic [4:0]                   cap_sense_a_channel,
    input wire logic [2:0]                   cap_sense_b_channel,
    input wire logic                         timer_gate_input
);
    logic wr_done;
    logic rd_port;
    assign wr_done = apb_req.psel & apb_req.penable & pready &
                     apb_req.pwrite & apb_req.pstrb[0];
    assign rd_port = !apb_req.pwrite && apb_req.paddr == `PORT_PIN_DATA_OFS;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    a_read_answer: assert property (
        apb_req.psel && !apb_req.penable && clk_en && rd_port ##1 clk_en
        |-> pready && prdata[31:8] == 24'h0) else $error("read not answered");
    a_read_levels: assert property (
        pready && apb_req.penable && rd_port |-> (prdata[7:0] &
        ~$past({cap_sense_a_channel, cap_sense_b_channel})) == 8'h00)
        else $error("read shows level not on pins");
    a_dir_write: assert property (
        wr_done && apb_req.paddr == `PIN_DIRECTION_OFS
        |=> pad_drive.pin_oe_b == $past(apb_req.pwdata[7:0]))
        else $error("driver enable not written");
    a_latch_write: assert property (
        wr_done && apb_req.paddr == `PORT_PIN_DATA_OFS
        |=> pad_drive.pin_out == $past(apb_req.pwdata[7:0]))
        else $error("latch not written");
    a_enable_hold: assert property (
        $changed(pad_drive.pin_oe_b)
        |-> $past(wr_done && apb_req.paddr == `PIN_DIRECTION_OFS))
        else $error("driver enable changed alone");
    a_analog_drive: assert property (
        wr_done && apb_req.paddr == `ANALOG_SELECT_OFS |=> $stable(pad_drive))
        else $error("analog select moved drivers");
    a_gate_tap: assert property (
        timer_gate_input && $stable(timer_gate_input) &&
        $stable(cap_sense_b_channel) |-> cap_sense_b_channel[0])
        else $error("gate high with pin low");
    a_reset_safe: assert property (
        $rose(rst_b) |-> pad_drive.pin_oe_b == `PIN_DIRECTION_RESET)
        else $error("drivers on after reset");
endmodule
bind gpio_port gpio_port_assertions chk_i (.mclk(mclk), .rst_b(rst_b),
    .clk_en(clk_en), .apb_req(apb_req), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .pin_in(pin_in), .pad_drive(pad_drive),
    .cap_sense_a_channel(cap_sense_a_channel),
    .cap_sense_b_channel(cap_sense_b_channel),
    .timer_gate_input(timer_gate_input));

// ===== dv/pin_board.sv
`timescale 1ns/1ns
module pin_board (
    input wire gpio_port_pkg::pad_drive_type pad_drive,
    input wire logic [7:0]                   ext_val,
    output logic [7:0]                       pin_in
);
    // Board source only reaches pins whose driver is off
    always_comb
        for (int i = 0; i < 8; i++)
            pin_in[i] = pad_drive.pin_oe_b[i] ? ext_val[i]
                                              : pad_drive.pin_out[i];
endmodule

// ===== dv/tb.sv
`timescale 1ns/1ns
`include "gpio_port_map.svh"
module tb;
    logic                         mclk = 0;
    logic                         rst_b = 0;
    logic                         clk_en = 1;
    gpio_port_pkg::apb_req_type   req = '0;
    gpio_port_pkg::pad_drive_type pad;
    logic                         pready, pslverr, tg;
    logic [31:0]                  prdata;
    logic [7:0]                   ext = 8'h00, pins, d, m, lv;
    logic [4:0]                   ca;
    logic [2:0]                   cb;
    logic [32:0]                  exp_q[$];
    int                           bad_count = 0, tests_run = 0, seed = 88852;
    always #25 mclk = ~mclk;
    gpio_port uut (.mclk(mclk), .rst_b(rst_b), .clk_en(clk_en),
        .apb_req(req), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .pin_in(pins), .pad_drive(pad), .cap_sense_a_channel(ca),
        .cap_sense_b_channel(cb), .timer_gate_input(tg));
    pin_board board (.pad_drive(pad), .ext_val(ext), .pin_in(pins));
    task automatic chk(input string nm, input logic [32:0] seen,
                       input logic [32:0] want);
        tests_run++;
        if (seen !== want) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, want, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] dt, input logic [3:0] s);
        int n;
        n = 0;
        req <= '{1'b1, 1'b0, w, a, {24'h0, dt}, s};
        @(posedge mclk);
        req.penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge mclk);
        end
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (pready !== 1'b1) begin
            bad_count++;
            finish_test();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] dt);
        apb(1'b1, a, dt, 4'hF);
        @(posedge mclk);
    endtask
    // Idle first so the two-flop sync has caught up with the pins
    task automatic rd(input logic [11:0] a, input logic [32:0] want);
        repeat (4) @(posedge mclk);
        exp_q.push_back(want);
        apb(1'b0, a, 8'h00, 4'hF);
    endtask
    always @(posedge mclk)
        if (req.psel && req.penable && pready === 1'b1 && !req.pwrite) begin
            if (exp_q.size() == 0)
                chk("read queue", 33'h0, 33'h1);
            else
                chk("prdata", {pslverr, prdata}, exp_q.pop_front());
        end
    initial begin
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        chk("oe_b", pad.pin_oe_b, 33'hFF);
        rd(`PIN_DIRECTION_OFS, 33'hFF);
        rd(`ANALOG_SELECT_OFS, 33'hFF);
        ext <= 8'($random(seed));
        rd(`PORT_PIN_DATA_OFS, 33'h0);
        $display("test reset done");
        wr(`ANALOG_SELECT_OFS, 8'h00);
        for (int i = 0; i < 4; i++) begin
            ext <= 8'($random(seed));
            @(posedge mclk);
            rd(`PORT_PIN_DATA_OFS, {25'h0, ext});
        end
        $display("test input done");
        d = 8'($random(seed));
        wr(`PORT_PIN_DATA_OFS, d);
        wr(`PIN_DIRECTION_OFS, 8'h0F);
        chk("pin_out", pad.pin_out, d);
        chk("oe_b", pad.pin_oe_b, 33'h0F);
        lv = {d[7:4], ext[3:0]};
        rd(`PORT_PIN_DATA_OFS, {25'h0, lv});
        m = 8'($random(seed));
        wr(`PORT_BIT_TOGGLE_OFS, m);
        lv = lv ^ m;
        chk("pin_out", pad.pin_out, lv);
        $display("test output done");
        wr(`ANALOG_SELECT_OFS, 8'hF0);
        chk("oe_b", pad.pin_oe_b, 33'h0F);
        chk("pin_out", pad.pin_out, lv);
        rd(`PORT_PIN_DATA_OFS, {29'h0, ext[3:0]});
        chk("gate", tg, ext[0]);
        wr(`PORT_BIT_CLEAR_OFS, 8'h01);
        chk("pin_out", pad.pin_out, {4'h0, ext[3:1], 1'b0});
        wr(`PIN_DIRECTION_OFS, 8'hF0);
        rd(12'h01C, {1'b1, 32'h0});
        chk("cap_a", ca, ext[7:3]);
        @(posedge mclk);
        apb(1'b1, `PIN_DIRECTION_OFS, 8'h00, 4'hE);
        rd(`PIN_DIRECTION_OFS, 33'hF0);
        wr(`PORT_BIT_SET_OFS, 8'h01);
        wr(`OUTPUT_LATCH_OFS, 8'hAA);
        lv = {4'h0, ext[3:1], 1'b1};
        chk("pin_out", pad.pin_out, lv);
        rd(`OUTPUT_LATCH_OFS, {25'h0, lv});
        chk("gate", tg, 1'b1);
        $display("test analog done");
        // Enable dropped between setup and access stretches the read
        fork
            rd(`PORT_PIN_DATA_OFS, {25'h0, lv});
            begin
                repeat (5) @(posedge mclk);
                clk_en <= 1'b0;
                repeat (3) @(posedge mclk);
                clk_en <= 1'b1;
            end
        join
        $display("test enable done");
        rst_b <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        chk("oe_b", pad.pin_oe_b, 33'hFF);
        rd(`ANALOG_SELECT_OFS, 33'hFF);
        rd(`PORT_PIN_DATA_OFS, 33'h0);
        $display("test second reset done");
        finish_test();
    end
endmodule
